// >>> core/csc_pkg.sv
// Purpose: shared constants and types for the cache snoop/config link
// Assumes: one processor clock, sys_clk, at 40 MHz
// Notes:   configuration word layout is shared by both ends
package csc_pkg;
  localparam int CFG_W          = 10;
  localparam int CFG_SIZE_BIT   = 0;   // 0 = 256 KB, 1 = 512 KB
  localparam int CFG_TAG_BIT    = 1;   // 0 = 4K tags, 1 = 8K tags
  localparam int CFG_WIDE_BIT   = 2;   // 0 = 64-bit, 1 = 128-bit memory bus
  localparam int CFG_ORDER_BIT  = 3;   // 0 = weak, 1 = strong write ordering
  localparam int CFG_SECT_BIT   = 4;   // 0 = one line, 1 = two lines per sector
  localparam int CFG_RATIO_LSB  = 5;   // 2 bits: 0 = 1:1, 1 = 1:2, 2 = 1:4
  localparam int CFG_XFER_BIT   = 7;   // 0 = four, 1 = eight transfers per line
  localparam int CFG_SNP_LSB    = 8;   // 2 bits: snoop mode
  localparam logic [CFG_W-1:0] CFG_RESET = 10'h000;
  localparam int MEM_MODE_W     = 1;
  localparam int ADDR_W         = 32;
  localparam int RESP_W         = 2;
  localparam int LINK_DIV       = 4;   // adapter snoop clock divider half period
  typedef enum logic [1:0]
  {
    CSC_SNP_SYNC   = 2'b00,
    CSC_SNP_CLOCK  = 2'b01,
    CSC_SNP_STROBE = 2'b10
  } csc_snp_mode_t;
  typedef enum logic [1:0]
  {
    CSC_RSP_MISS  = 2'b00,
    CSC_RSP_HIT   = 2'b01,
    CSC_RSP_HITM  = 2'b10
  } csc_resp_t;
  function automatic logic [1:0] csc_ratio(input logic [CFG_W-1:0] c);
    csc_ratio = c[CFG_RATIO_LSB +: 2];
  endfunction
endpackage

// >>> core/csc_link_if.sv
// Purpose: pins between cache controller and system bus adapter
// Assumes: two-way cfg pins split into one signal and one enable per end, never resolved
// Notes:   enables high while driving
`timescale 1ns/1ps
interface csc_link_if;
  logic                          rstN;
  logic [csc_pkg::CFG_W-1:0]     cfgPins;
  logic                          cfgPinsOe;
  logic [csc_pkg::CFG_W-1:0]     cfgPinsFromDev;
  logic                          cfgPinsDevOe;
  logic                          snoopValid;
  logic [csc_pkg::ADDR_W-1:0]    snoopAddr;
  logic                          snoop_sample_clock;
  logic                          snoop_capture_strobe_n;
  logic                          snoopBusy;
  logic                          respValid;
  logic [csc_pkg::RESP_W-1:0]    respCode;
  logic                          memClk;
  logic [csc_pkg::MEM_MODE_W-1:0] memMode;
  logic                          memOutStrobe;
  logic                          memInStrobe;
  logic                          snoopParity;
  logic [7:0]                    latched_byte_enable_n;
  logic                          latched_cacheable_n;
  logic                          latched_page_no_cache;
  logic                          latched_page_write_through;
  logic                          latched_split_cycle;
  modport device (input rstN, cfgPins, cfgPinsOe, snoopValid, snoopAddr, snoop_sample_clock,
    snoop_capture_strobe_n, memClk, memMode, memOutStrobe, memInStrobe, snoopParity,
    output cfgPinsFromDev, cfgPinsDevOe, snoopBusy, respValid, respCode,
    latched_byte_enable_n, latched_cacheable_n, latched_page_no_cache,
    latched_page_write_through, latched_split_cycle);
  modport adapter (output rstN, cfgPins, cfgPinsOe, snoopValid, snoopAddr,
    snoop_sample_clock, snoop_capture_strobe_n, memClk, memMode, memOutStrobe,
    memInStrobe, snoopParity,
    input cfgPinsFromDev, cfgPinsDevOe, snoopBusy, respValid, respCode,
    latched_byte_enable_n, latched_cacheable_n, latched_page_no_cache,
    latched_page_write_through, latched_split_cycle);
endinterface

// >>> core/csc_cache_ctrl.sv
// Purpose: cache controller end: config latch, snoop capture, response, attribute latch
// Assumes: link inputs are asynchronous to sys_clk except in synchronous snoop mode
// Notes:   snoop lookup is modelled by a small address-match table
`timescale 1ns/1ps
// Contract
// - config held during reset, never changed after
// - shared config pins become outputs after reset
// - size, tags, bus width, write ordering selectable
// - sectoring, line ratio, transfers per line selectable
// - three snoop start modes, response synchronous
// - sync mode: capture on clock, snoop next edge
// - sync response on edge after snoop
// - clocked mode: capture on snoop clock, synchronise
// - strobed mode: capture on strobe fall, synchronise
// - memory mode independent of snoop mode
// - clocked memory: data timed to memory clock
// - strobed memory: drive and capture on separate strobes
// - latch processor attributes, re-drive latched copies
// - adapter holds snoops while busy, forwards response
// - adapter resolves other caches' snoop results
// - adapter controls and synchronises memory cycles
// - adapter supplies parity during snoops
module csc_cache_ctrl
  import csc_pkg::*;
#(
  parameter int TAG_ENTRIES = 4
)
(
  input  wire logic                  sys_clk,        // processor clock
  csc_link_if.device                 link,           // adapter pins
  input  wire logic [7:0]            cpu_byte_enables_n, // processor byte enables
  input  wire logic                  cpuCacheReq,    // processor cacheability request
  input  wire logic                  page_no_cache,  // processor page cache disable
  input  wire logic                  page_write_through, // processor page write-through
  input  wire logic                  split_cycle_flag, // processor split cycle
  input  wire logic                  cpuAttrLatch,   // attribute latch strobe
  input  wire logic                  lookupBusy,     // internal resources busy
  input  wire logic                  tagWrite,       // load a modelled tag
  input  wire logic [ADDR_W-1:0]     tagAddr,        // address for loaded tag
  input  wire logic                  tagDirty,       // loaded line is modified
  output logic [CFG_W-1:0]           cfgWord,        // frozen configuration
  output logic [MEM_MODE_W-1:0]      memModeCfg,     // frozen memory bus mode
  output logic                       memDataEn,      // memory data timing pulse
  output logic                       memCaptureEn,   // memory capture timing pulse
  output logic                       parityCaptured  // parity seen on last snoop
);
  import csc_pkg::*;
  logic              rstN;
  assign rstN = link.rstN;
  logic              cfgDone_r, cfgDone_nxt;
  logic [CFG_W-1:0]  cfg_r, cfg_nxt;
  logic [MEM_MODE_W-1:0] memMode_r, memMode_nxt;
  // synchronisers, first stage read only by second
  logic [2:0] sck1_r, sck2_r, sck3_r, stb1_r, stb2_r, stb3_r;
  logic [2:0] mclk_r, mos_r, mis_r;
  logic       vld1_r, vld2_r;
  // link-domain captures: addresses hold stable while request pending
  logic [ADDR_W-1:0] capAddr_r, capAddr_nxt;
  logic              capPend_r, capPend_nxt;
  logic              doSnoop_r, doSnoop_nxt;
  logic [ADDR_W-1:0] snAddr_r, snAddr_nxt;
  logic              respValid_r, respValid_nxt;
  logic [RESP_W-1:0] respCode_r, respCode_nxt;
  logic              busy_r, busy_nxt;
  logic [ADDR_W-1:0] tagA_r [TAG_ENTRIES];
  logic [TAG_ENTRIES-1:0] tagV_r, tagM_r;
  logic [$clog2(TAG_ENTRIES)-1:0] tagPtr_r;
  logic [12:0]       attr_r, attr_nxt;
  logic              memEn_r, memEn_nxt, memCap_r, memCap_nxt, par_r, par_nxt;
  logic              outEn_r, outEn_nxt;
  csc_snp_mode_t     mode;
  logic              sckRise, stbFall, sysReq;
  assign mode    = csc_snp_mode_t'(cfg_r[CFG_SNP_LSB +: 2]);
  assign sckRise = sck2_r[0] & ~sck3_r[0];
  assign stbFall = ~stb2_r[0] & stb3_r[0];
  assign sysReq  = link.snoopValid;
  always_ff @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      {sck1_r, sck2_r, sck3_r, stb1_r, stb2_r, stb3_r} <= '0;
      {mclk_r, mos_r, mis_r, vld1_r, vld2_r} <= '0;
    end
    else
    begin
      sck1_r <= {2'b00, link.snoop_sample_clock};
      sck2_r <= sck1_r;
      sck3_r <= sck2_r;
      stb1_r <= {2'b00, link.snoop_capture_strobe_n};
      stb2_r <= stb1_r;
      stb3_r <= stb2_r;
      mclk_r <= {mclk_r[1:0], link.memClk};
      mos_r  <= {mos_r[1:0], link.memOutStrobe};
      mis_r  <= {mis_r[1:0], link.memInStrobe};
      vld1_r <= link.snoopValid;
      vld2_r <= vld1_r;
    end
  end
  always_comb
  begin
    cfg_nxt     = cfg_r;
    memMode_nxt = memMode_r;
    cfgDone_nxt = 1'b1;
    outEn_nxt   = 1'b1;
    if (!cfgDone_r)
    begin
      cfg_nxt     = link.cfgPins;
      memMode_nxt = link.memMode;
    end
    capAddr_nxt = capAddr_r;
    capPend_nxt = capPend_r;
    doSnoop_nxt = 1'b0;
    snAddr_nxt  = snAddr_r;
    par_nxt     = par_r;
    // a sync snoop met while busy is held, since the adapter drops valid after one cycle
    if ((mode == CSC_SNP_CLOCK && sckRise && vld2_r)
        || (mode == CSC_SNP_STROBE && stbFall)
        || (mode == CSC_SNP_SYNC && sysReq && lookupBusy))
    begin
      capPend_nxt = 1'b1;
      capAddr_nxt = link.snoopAddr;
    end
    if (!lookupBusy)
    begin
      if (mode == CSC_SNP_SYNC && sysReq)
      begin
        doSnoop_nxt = 1'b1;
        snAddr_nxt  = link.snoopAddr;
        par_nxt     = link.snoopParity;
      end
      else if (capPend_r)
      begin
        doSnoop_nxt = 1'b1;
        snAddr_nxt  = capAddr_r;
        capPend_nxt = 1'b0;
        par_nxt     = link.snoopParity;
      end
    end
    busy_nxt      = lookupBusy | capPend_nxt;
    respValid_nxt = doSnoop_r;
    respCode_nxt  = CSC_RSP_MISS;
    for (int i = 0; i < TAG_ENTRIES; i++)
    begin
      if (tagV_r[i] && tagA_r[i] == snAddr_r)
        respCode_nxt = tagM_r[i] ? CSC_RSP_HITM : CSC_RSP_HIT;
    end
    if (!doSnoop_r)
      respCode_nxt = respCode_r;
    attr_nxt = attr_r;
    if (cpuAttrLatch)
      attr_nxt = {cpu_byte_enables_n, ~cpuCacheReq, page_no_cache,
                  page_write_through, split_cycle_flag, 1'b0};
    if (memMode_r == '0)
    begin
      memEn_nxt  = mclk_r[1] & ~mclk_r[2];
      memCap_nxt = memEn_nxt;
    end
    else
    begin
      memEn_nxt  = mos_r[1] & ~mos_r[2];
      memCap_nxt = mis_r[1] & ~mis_r[2];
    end
  end
  always_ff @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      cfgDone_r <= 1'b0;
      cfg_r <= CFG_RESET;
      memMode_r <= '0;
      outEn_r <= 1'b0;
      capAddr_r <= '0;
      capPend_r <= 1'b0;
      doSnoop_r <= 1'b0;
      snAddr_r <= '0;
      respValid_r <= 1'b0;
      respCode_r <= '0;
      busy_r <= 1'b1;
      attr_r <= {8'hFF, 5'h10};
      memEn_r <= 1'b0;
      memCap_r <= 1'b0;
      par_r <= 1'b0;
    end
    else
    begin
      cfgDone_r <= cfgDone_nxt;
      cfg_r <= cfg_nxt;
      memMode_r <= memMode_nxt;
      outEn_r <= outEn_nxt;
      capAddr_r <= capAddr_nxt;
      capPend_r <= capPend_nxt;
      doSnoop_r <= doSnoop_nxt;
      snAddr_r <= snAddr_nxt;
      respValid_r <= respValid_nxt;
      respCode_r <= respCode_nxt;
      busy_r <= busy_nxt;
      attr_r <= attr_nxt;
      memEn_r <= memEn_nxt;
      memCap_r <= memCap_nxt;
      par_r <= par_nxt;
    end
  end
  // tag model: round-robin fill
  always_ff @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      tagV_r <= '0;
      tagM_r <= '0;
      tagPtr_r <= '0;
      for (int i = 0; i < TAG_ENTRIES; i++)
        tagA_r[i] <= '0;
    end
    else if (tagWrite)
    begin
      tagA_r[tagPtr_r] <= tagAddr;
      tagV_r[tagPtr_r] <= 1'b1;
      tagM_r[tagPtr_r] <= tagDirty;
      tagPtr_r <= tagPtr_r + 1'b1;
    end
  end
  assign link.cfgPinsFromDev = {{(CFG_W-RESP_W){1'b0}}, respCode_r};
  assign link.cfgPinsDevOe   = outEn_r;
  assign link.snoopBusy      = busy_r;
  assign link.respValid      = respValid_r;
  assign link.respCode       = respCode_r;
  assign link.latched_byte_enable_n      = attr_r[12:5];
  assign link.latched_cacheable_n        = attr_r[4];
  assign link.latched_page_no_cache      = attr_r[3];
  assign link.latched_page_write_through = attr_r[2];
  assign link.latched_split_cycle        = attr_r[1];
  assign cfgWord        = cfg_r;
  assign memModeCfg     = memMode_r;
  assign memDataEn      = memEn_r;
  assign memCaptureEn   = memCap_r;
  assign parityCaptured = par_r;
endmodule

// >>> core/csc_bus_adapter.sv
// Purpose: system bus adapter end: drives config, reset, snoops, forwards response
// Assumes: user supplies snoop requests and snoop results of other caches
// Notes:   snoop clock made here by divider
`timescale 1ns/1ps
module csc_bus_adapter
  import csc_pkg::*;
(
  input  wire logic              sys_clk,      // processor clock
  input  wire logic              rst_n,        // async reset, active low
  csc_link_if.adapter            link,         // device pins
  input  wire logic [CFG_W-1:0]  cfgSel,       // configuration to present
  input  wire logic [MEM_MODE_W-1:0] memSel,   // memory bus mode
  input  wire logic              reqValid,     // user snoop request
  input  wire logic [ADDR_W-1:0] reqAddr,      // snoop address
  input  wire logic              reqParity,    // data parity for snoop
  input  wire logic [1:0]        peerResult,   // 0 ok, 1 abort, 2 writeback first
  output logic                   reqTaken,     // request issued
  output logic                   sysRespValid, // forwarded response
  output logic [RESP_W-1:0]      sysRespCode,  // forwarded code
  output logic [1:0]             cycleAction   // 0 update, 1 abort, 2 delay
);
  import csc_pkg::*;
  logic [2:0] div_r, div_nxt;
  logic sck_r, sck_nxt, stb_r, stb_nxt, vld_r, vld_nxt, tk_r, tk_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic par_r, par_nxt, rv_r, rv_nxt;
  logic [1:0] modeHold_r, modeHold_nxt;
  logic [RESP_W-1:0] rc_r, rc_nxt;
  logic [1:0] act_r, act_nxt;
  logic [1:0] rls_r;
  csc_snp_mode_t mode;
  // snoop mode frozen at reset release, like the device's copy
  assign mode = csc_snp_mode_t'(modeHold_r);
  always_comb
  begin
    div_nxt = (div_r == 3'(LINK_DIV - 1)) ? 3'd0 : div_r + 3'd1;
    sck_nxt = (div_r == 3'(LINK_DIV - 1)) ? ~sck_r : sck_r;
    vld_nxt = vld_r;
    stb_nxt = 1'b1;
    addr_nxt = addr_r;
    par_nxt = par_r;
    tk_nxt  = 1'b0;
    modeHold_nxt = rls_r[0] ? modeHold_r : cfgSel[CFG_SNP_LSB +: 2];
    // clocked mode: valid must stand across a snoop clock rise, so drop it on the fall
    if (vld_r && (mode == CSC_SNP_SYNC || (div_r == 3'(LINK_DIV - 1) && sck_r)))
      vld_nxt = 1'b0;
    else if (!vld_r && reqValid && !link.snoopBusy && rls_r[1]
             && (mode != CSC_SNP_CLOCK || !sck_r))
    begin
      vld_nxt = 1'b1;
      stb_nxt = (mode != CSC_SNP_STROBE);
      addr_nxt = reqAddr;
      par_nxt = reqParity;
      tk_nxt = 1'b1;
    end
    rv_nxt = link.respValid;
    rc_nxt = link.respValid ? link.respCode : rc_r;
    act_nxt = (peerResult == 2'd1) ? 2'd1 : (peerResult == 2'd2) ? 2'd2 : 2'd0;
  end
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_r <= '0; sck_r <= 1'b0; stb_r <= 1'b1; vld_r <= 1'b0; tk_r <= 1'b0;
      addr_r <= '0; par_r <= 1'b0; modeHold_r <= '0;
      rv_r <= 1'b0; rc_r <= '0; act_r <= '0; rls_r <= '0;
    end
    else
    begin
      div_r <= div_nxt; sck_r <= sck_nxt; stb_r <= stb_nxt; vld_r <= vld_nxt;
      tk_r <= tk_nxt; addr_r <= addr_nxt; par_r <= par_nxt;
      modeHold_r <= modeHold_nxt;
      rv_r <= rv_nxt; rc_r <= rc_nxt; act_r <= act_nxt;
      rls_r <= {rls_r[0], 1'b1};
    end
  end
  assign link.rstN = rst_n;
  assign link.cfgPins = cfgSel;
  assign link.cfgPinsOe = ~rst_n;
  assign link.memMode = memSel;
  assign link.snoopValid = vld_r;
  assign link.snoopAddr = addr_r;
  assign link.snoop_sample_clock = sck_r;
  assign link.snoop_capture_strobe_n = stb_r;
  assign link.memClk = sck_r;
  assign link.memOutStrobe = sck_r;
  assign link.memInStrobe = ~sck_r;
  assign link.snoopParity = par_r;
  assign reqTaken = tk_r;
  assign sysRespValid = rv_r;
  assign sysRespCode = rc_r;
  assign cycleAction = act_r;
endmodule

// >>> bench/csc_link_chk.sv
// Purpose: concurrent checks on the pins between cache controller and bus adapter
// Assumes: sys_clk samples every pin; rstN is the link reset from the adapter
// Notes:   snoop mode is taken from the config pins while reset is low
`timescale 1ns/1ps
module csc_link_chk
  import csc_pkg::*;
(
  input wire logic                       sys_clk,                // processor clock
  input wire logic                       rstN,                   // link reset
  input wire logic [csc_pkg::CFG_W-1:0]  cfgPins,                // config from adapter
  input wire logic                       cfgPinsOe,              // adapter drives config
  input wire logic                       cfgPinsDevOe,           // device drives pins
  input wire logic                       snoopValid,             // snoop start
  input wire logic                       snoop_capture_strobe_n, // snoop strobe
  input wire logic                       snoopBusy,              // hold off snoops
  input wire logic                       respValid,              // response pulse
  input wire logic [csc_pkg::RESP_W-1:0] respCode,               // response code
  input wire logic [7:0]                 latched_byte_enable_n   // latched byte enables
);
  logic [1:0] modeR;
  logic [1:0] modeNxt;
  logic       clkSeen;
  // mode is only meaningful on the pins during reset
  always_comb
  begin
    modeNxt = rstN ? modeR : cfgPins[CFG_SNP_LSB +: 2];
  end
  always_ff @(posedge sys_clk)
  begin
    modeR <= modeNxt;
    clkSeen <= 1'b1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstN);
  a_cfg_released: assert property (rstN && $past(rstN, 2) |-> !cfgPinsOe)
    else $error("adapter still drives config pins");
  a_pins_turned: assert property (rstN && $past(rstN, 2) |-> cfgPinsDevOe)
    else $error("device does not drive shared pins");
  a_no_fight: assert property (!(cfgPinsOe && cfgPinsDevOe))
    else $error("both ends drive shared pins");
  a_sync_latency: assert property (respValid && modeR == CSC_SNP_SYNC
    |-> $past(snoopValid, 2))
    else $error("sync response not two edges after take");
  a_clk_bounded: assert property ($rose(snoopValid) && modeR == CSC_SNP_CLOCK
    |-> ##[3:60] respValid)
    else $error("clocked snoop gets no response");
  a_stb_bounded: assert property ($fell(snoop_capture_strobe_n) && modeR == CSC_SNP_STROBE
    |-> ##[2:60] respValid)
    else $error("strobed snoop gets no response");
  a_resp_pulse: assert property (respValid |=> !respValid ##1 $stable(respCode))
    else $error("response not a single pulse");
  a_hold_off: assert property (snoopBusy && !snoopValid |=> !snoopValid)
    else $error("snoop started while busy");
  // skip the very first edge: reset at time zero may not have reached the flops yet
  a_attr_reset: assert property (disable iff (1'b0)
    !rstN && clkSeen |-> latched_byte_enable_n == 8'hFF)
    else $error("latched byte enables not idle in reset");
endmodule

// >>> bench/cache_snoop_config_interface_bench.sv
// Purpose: runs both link ends against each other through all snoop modes
// Assumes: adapter makes snoop clock and memory timing from its own divider
// Notes:   one reset per snoop mode, since config is frozen after reset
`timescale 1ns/1ps
module cache_snoop_config_interface_bench;
  import csc_pkg::*;
  logic              sysClk;
  logic              rstN;
  logic [CFG_W-1:0]  cfgSel;
  logic [0:0]        memSel;
  logic              reqValid;
  logic [ADDR_W-1:0] reqAddr;
  logic              reqParity;
  logic [1:0]        peerResult;
  logic              reqTaken;
  logic              sysRespValid;
  logic [RESP_W-1:0] sysRespCode;
  logic [1:0]        cycleAction;
  logic [7:0]        cpuBe;
  logic              cpuCacheReq;
  logic              pageNoCache;
  logic              pageWt;
  logic              splitCyc;
  logic              cpuAttrLatch;
  logic              lookupBusy;
  logic              tagWrite;
  logic [ADDR_W-1:0] tagAddr;
  logic              tagDirty;
  logic [CFG_W-1:0]  cfgWord;
  logic [0:0]        memModeCfg;
  logic              memDataEn;
  logic              memCaptureEn;
  logic              parityCaptured;
  int                error_cnt;
  int                checks;
  int                lat;
  int                dataCnt;
  int                capCnt;
  logic [CFG_W-1:0]  cfgs [3] = '{10'h0A5, 10'h15A, 10'h21F};
  csc_link_if link();
  csc_cache_ctrl i_csc_cache_ctrl (.sys_clk(sysClk), .link(link), .cpu_byte_enables_n(cpuBe),
    .cpuCacheReq(cpuCacheReq), .page_no_cache(pageNoCache), .page_write_through(pageWt),
    .split_cycle_flag(splitCyc), .cpuAttrLatch(cpuAttrLatch), .lookupBusy(lookupBusy),
    .tagWrite(tagWrite), .tagAddr(tagAddr), .tagDirty(tagDirty), .cfgWord(cfgWord),
    .memModeCfg(memModeCfg), .memDataEn(memDataEn), .memCaptureEn(memCaptureEn),
    .parityCaptured(parityCaptured));
  csc_bus_adapter i_csc_bus_adapter (.sys_clk(sysClk), .rst_n(rstN), .link(link),
    .cfgSel(cfgSel), .memSel(memSel), .reqValid(reqValid), .reqAddr(reqAddr),
    .reqParity(reqParity), .peerResult(peerResult), .reqTaken(reqTaken),
    .sysRespValid(sysRespValid), .sysRespCode(sysRespCode), .cycleAction(cycleAction));
  csc_link_chk i_csc_link_chk (.sys_clk(sysClk), .rstN(link.rstN), .cfgPins(link.cfgPins),
    .cfgPinsOe(link.cfgPinsOe), .cfgPinsDevOe(link.cfgPinsDevOe), .snoopValid(link.snoopValid),
    .snoop_capture_strobe_n(link.snoop_capture_strobe_n), .snoopBusy(link.snoopBusy),
    .respValid(link.respValid), .respCode(link.respCode),
    .latched_byte_enable_n(link.latched_byte_enable_n));
  initial
  begin
    sysClk = 1'b0;
    forever #12.5 sysClk = ~sysClk;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic do_reset(input logic [CFG_W-1:0] c, input logic m);
    @(negedge sysClk);
    rstN = 1'b0;
    cfgSel = c;
    memSel = m;
    repeat (2) @(negedge sysClk);
    rstN = 1'b1;
    repeat (3) @(negedge sysClk);
  endtask
  task automatic load_tag(input logic [ADDR_W-1:0] a, input logic d);
    @(negedge sysClk);
    tagWrite = 1'b1;
    tagAddr = a;
    tagDirty = d;
    @(negedge sysClk);
    tagWrite = 1'b0;
  endtask
  // hold request until taken; bounded waits so a stuck end cannot hang the run
  task automatic snoop(input logic [ADDR_W-1:0] a, input logic p, input logic [1:0] e,
                       output int n);
    int i;
    @(negedge sysClk);
    reqValid = 1'b1;
    reqAddr = a;
    reqParity = p;
    for (i = 0; i < 80 && reqTaken !== 1'b1; i++)
      @(negedge sysClk);
    reqValid = 1'b0;
    n = 0;
    while (n < 80 && sysRespValid !== 1'b1)
    begin
      @(negedge sysClk);
      n++;
    end
    check("sysRespValid", 32'h0000_0001, {31'h0000_0000, sysRespValid});
    check("sysRespCode", {30'h0000_0000, e}, {30'h0000_0000, sysRespCode});
  endtask
  initial
  begin
    repeat (20000) @(posedge sysClk);
    error_cnt++;
    tally_and_finish();
  end
  initial
  begin
    {rstN, reqValid, reqAddr, reqParity, peerResult, cpuCacheReq, cpuAttrLatch} = '0;
    {pageNoCache, pageWt, splitCyc, lookupBusy, tagWrite, tagAddr, tagDirty} = '0;
    cfgSel = 10'h000;
    memSel = 1'b0;
    cpuBe = 8'hFF;
    for (int m = 0; m < 3; m++)
    begin
      do_reset(cfgs[m], m[0]);
      check("cfgWord", 32'(cfgs[m]), 32'(cfgWord));
      check("memModeCfg", 32'(m[0]), 32'(memModeCfg));
      check("cfgPinsDevOe", 32'h0000_0001, 32'(link.cfgPinsDevOe));
      check("latchedBe", 32'h0000_00FF, 32'(link.latched_byte_enable_n));
      check("respValid", 32'h0000_0000, 32'(link.respValid));
      cfgSel = ~cfgs[m];
      dataCnt = 0;
      capCnt = 0;
      repeat (40)
      begin
        @(negedge sysClk);
        dataCnt += int'(memDataEn);
        capCnt += int'(memCaptureEn);
      end
      check("cfgWord frozen", 32'(cfgs[m]), 32'(cfgWord));
      check("memDataEn seen", 32'h0000_0001, 32'(dataCnt > 0));
      check("memCaptureEn seen", 32'h0000_0001, 32'(capCnt > 0));
      load_tag(32'h0000_1000, 1'b0);
      load_tag(32'h0000_2000, 1'b1);
      snoop(32'h0000_1000, 1'b1, CSC_RSP_HIT, lat);
      check("parityCaptured", 32'h0000_0001, 32'(parityCaptured));
      if (m == 0)
        check("sync latency", 32'h0000_0003, 32'(lat));
      snoop(32'h0000_2000, 1'b0, CSC_RSP_HITM, lat);
      check("parityCaptured", 32'h0000_0000, 32'(parityCaptured));
      lookupBusy = 1'b1;
      @(negedge sysClk);
      check("snoopBusy", 32'h0000_0001, 32'(link.snoopBusy));
      fork
        begin
          repeat (10) @(negedge sysClk);
          lookupBusy = 1'b0;
        end
      join_none
      snoop(32'h0000_3000, 1'b0, CSC_RSP_MISS, lat);
      check("snoopBusy", 32'h0000_0000, 32'(link.snoopBusy));
      $display("test snoop mode %0d done", m);
    end
    for (int p = 0; p < 3; p++)
    begin
      peerResult = 2'(p);
      repeat (3) @(negedge sysClk);
      check("cycleAction", 32'(p), 32'(cycleAction));
    end
    $display("test peer results done");
    cpuBe = 8'h5A;
    {cpuCacheReq, pageNoCache, pageWt, splitCyc} = 4'b1101;
    cpuAttrLatch = 1'b1;
    @(negedge sysClk);
    cpuAttrLatch = 1'b0;
    cpuBe = 8'hA5;
    {cpuCacheReq, pageNoCache, pageWt, splitCyc} = 4'b0010;
    repeat (2) @(negedge sysClk);
    check("latchedBe", 32'h0000_005A, 32'(link.latched_byte_enable_n));
    check("latchedCache", 32'h0000_0000, 32'(link.latched_cacheable_n));
    check("latchedPcd", 32'h0000_0001, 32'(link.latched_page_no_cache));
    check("latchedPwt", 32'h0000_0000, 32'(link.latched_page_write_through));
    check("latchedScyc", 32'h0000_0001, 32'(link.latched_split_cycle));
    $display("test attribute latch done");
    tally_and_finish();
  end
endmodule
